//--- spwa_pkg.sv
// Shared constants for the shared prescaler and watchdog block
`default_nettype none
package spwa_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_OPTION = 8'h00;
  localparam logic [7:0] ADDR_TIMER = 8'h04;
  localparam logic [7:0] ADDR_WDCLEAR = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // Option register fields
  localparam int OPT_CLK_SEL_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_RATE_W = 3;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  // Status register fields
  localparam int ST_WDT_TO_BIT = 0;
  localparam int ST_TMR_OVF_BIT = 1;
  localparam int ST_PIN_BIT = 2;
  localparam int ST_ASSIGN_BIT = 3;
  // Cycle counts of the dividers and width of the prescaler rate field
  localparam int INSTR_DIV_DEFAULT = 4;
  localparam int WDT_BASE_DEFAULT = 65536;
  localparam int RATE_LOG2_W = 4;
endpackage
`default_nettype wire

//--- spwa_psc_if.sv
// Signals between the top logic and the shared prescaler
`default_nettype none
interface spwa_psc_if;
  logic tick;
  logic clear;
  logic [spwa_pkg::RATE_LOG2_W-1:0] rate_log2;
  logic done;
  modport owner (output tick, output clear, output rate_log2, input done);
  modport presc (input tick, input clear, input rate_log2, output done);
endinterface
`default_nettype wire

//--- spwa_prescaler.sv
// Shared power-of-two prescaler counter
`default_nettype none
module spwa_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  spwa_psc_if.presc psc
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  wire [WIDTH-1:0] mask;
  wire at_end;

  initial begin
    if (WIDTH < 1 || WIDTH > 15) begin
      $error("spwa_prescaler: WIDTH out of range");
    end
  end

  // Mask of the low bits that must all be set before an output pulse
  assign mask = WIDTH'(({{WIDTH{1'b0}}, 1'b1} << psc.rate_log2) - 1'b1);
  assign at_end = (count & mask) == mask;
  assign psc.done = psc.tick & at_end;

  always_comb begin
    next_count = count;
    if (psc.clear) begin
      next_count = '0;
    end else if (psc.tick) begin
      next_count = at_end ? '0 : WIDTH'(count + 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

//--- spwa_watchdog_top.sv
// Timer and watchdog sharing one prescaler, with an APB register slave
//
// Overview of operation
// [R1] Reset assigns prescaler to the watchdog
// [R2] External pin edges clock prescaler for timer
// [R3] Reset selects the external pin clock source
// [R4] Edge select set counts falling, clear rising
// [R5] Affected parts: reassignment adds one prescaler pulse
// [R6] That pulse at rate 1:1 gives time-out
// [R7] Software deselects pin clock before reassigning
// [R8] Or software sets edge opposite pin level
// [R9] Or software clears watchdog at non-1:1 rate
// [R10] Watchdog clear resets counter and prescaler; code clears the prescaler only while it is assigned to the watchdog
`default_nettype none
module spwa_watchdog_top #(
  parameter int WDT_BASE_CYCLES = spwa_pkg::WDT_BASE_DEFAULT,
  parameter int INSTR_DIV = spwa_pkg::INSTR_DIV_DEFAULT,
  parameter bit AFFECTED_REV = 1'b1,
  parameter int PSC_WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic ext_timer_clk_pin_in,
  input wire logic wdt_enable_in,
  output logic wdt_reset_out
);
  localparam int IW = (INSTR_DIV > 2) ? $clog2(INSTR_DIV) : 1;
  localparam int WW = (WDT_BASE_CYCLES > 2) ? $clog2(WDT_BASE_CYCLES) : 1;
  localparam logic [IW-1:0] INSTR_LAST = IW'(INSTR_DIV - 1);
  localparam logic [WW-1:0] WDT_LAST = WW'(WDT_BASE_CYCLES - 1);

  initial begin
    if (INSTR_DIV < 2) begin
      $error("spwa_watchdog_top: INSTR_DIV must be at least 2");
    end
    if (WDT_BASE_CYCLES < 2) begin
      $error("spwa_watchdog_top: WDT_BASE_CYCLES must be at least 2");
    end
    if (PSC_WIDTH < 8) begin
      $error("spwa_watchdog_top: PSC_WIDTH must reach rate 1:256");
    end
  end

  logic [7:0] option;
  logic [7:0] timer;
  logic wdt_to_flag;
  logic tmr_ovf_flag;
  logic [2:0] pin_sync;
  logic [1:0] en_sync;
  logic assign_q;
  logic [IW-1:0] instr_cnt;
  logic [WW-1:0] wdt_cnt;

  spwa_psc_if psc_bus ();

  spwa_prescaler #(
    .WIDTH(PSC_WIDTH)
  ) u_prescaler (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .psc(psc_bus)
  );

  // Option fields
  wire clk_sel_pin = option[spwa_pkg::OPT_CLK_SEL_BIT];
  wire edge_falling = option[spwa_pkg::OPT_EDGE_BIT];
  wire to_watchdog = option[spwa_pkg::OPT_ASSIGN_BIT];
  wire [2:0] rate_sel =
    option[spwa_pkg::OPT_RATE_LSB +: spwa_pkg::OPT_RATE_W];

  // APB decode
  wire apb_setup = psel_in & ~penable_in;
  wire apb_access = psel_in & penable_in;
  wire apb_wr = apb_access & pwrite_in;
  wire hit_option = paddr_in == spwa_pkg::ADDR_OPTION;
  wire hit_timer = paddr_in == spwa_pkg::ADDR_TIMER;
  wire hit_wdclear = paddr_in == spwa_pkg::ADDR_WDCLEAR;
  wire hit_status = paddr_in == spwa_pkg::ADDR_STATUS;
  wire hit_any = hit_option | hit_timer | hit_wdclear | hit_status;
  wire wr_option = apb_wr & hit_option;
  wire wr_timer = apb_wr & hit_timer;
  wire wr_status = apb_wr & hit_status;
  wire watchdog_clear_instr = apb_wr & hit_wdclear;

  assign pready_out = 1'b1;
  assign pslverr_out = apb_access & ~hit_any;

  // Synchronised pin level and its previous sample
  wire pin_level = pin_sync[1];
  wire pin_prev = pin_sync[2];
  wire wdt_enabled = en_sync[1];
  wire pin_rise = pin_level & ~pin_prev;
  wire pin_fall = ~pin_level & pin_prev;

  // [R4] Selected pin edge
  wire pin_edge = edge_falling ? pin_fall : pin_rise;

  wire instr_tick = instr_cnt == INSTR_LAST;
  wire wdt_base_tick = wdt_cnt == WDT_LAST;

  // [R2] Timer source is pin edges or instruction ticks
  wire timer_src = clk_sel_pin ? pin_edge : instr_tick;

  // [R5] Spurious pulse on return to the watchdog at the idle level
  wire reassign_glitch = AFFECTED_REV & to_watchdog & ~assign_q &
    clk_sel_pin & (pin_level == edge_falling);

  assign psc_bus.tick = to_watchdog ?
    (wdt_base_tick | reassign_glitch) : timer_src;
  // [R10] Clear reaches the prescaler only while it serves the watchdog
  assign psc_bus.clear = to_watchdog ? watchdog_clear_instr : wr_timer;
  assign psc_bus.rate_log2 = to_watchdog ?
    {1'b0, rate_sel} : 4'(rate_sel + 4'h1);

  wire timer_tick = to_watchdog ? timer_src : psc_bus.done;
  wire timer_wrap = timer_tick & (timer == 8'hff);

  // [R6] Prescaler output at 1:1 passes the glitch straight to time-out
  wire wdt_timeout = wdt_enabled &
    (to_watchdog ? psc_bus.done : wdt_base_tick);

  wire [7:0] status_byte = {4'h0, to_watchdog, pin_level,
    tmr_ovf_flag, wdt_to_flag};
  wire [31:0] rd_mux =
    hit_option ? {24'h00_0000, option} :
    hit_timer ? {24'h00_0000, timer} :
    hit_status ? {24'h00_0000, status_byte} : 32'h0000_0000;

  wire wdt_to_clr = wr_status & pwdata_in[spwa_pkg::ST_WDT_TO_BIT];
  wire tmr_ovf_clr = wr_status & pwdata_in[spwa_pkg::ST_TMR_OVF_BIT];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_sync <= 3'h0;
      en_sync <= 2'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], ext_timer_clk_pin_in};
      en_sync <= {en_sync[0], wdt_enable_in};
    end
  end

  // [R1] [R3] Option resets with pin source and watchdog assignment
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      option <= spwa_pkg::OPTION_RESET;
      assign_q <= 1'b1;
    end else begin
      assign_q <= to_watchdog;
      if (wr_option) begin
        option <= pwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      instr_cnt <= '0;
    end else begin
      instr_cnt <= instr_tick ? '0 : IW'(instr_cnt + 1'b1);
    end
  end

  // [R10] Watchdog clear restarts the base counter
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdt_cnt <= '0;
    end else if (watchdog_clear_instr || !wdt_enabled || wdt_base_tick) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= WW'(wdt_cnt + 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer <= spwa_pkg::TIMER_RESET;
    end else if (wr_timer) begin
      timer <= pwdata_in[7:0];
    end else if (timer_tick) begin
      timer <= 8'(timer + 8'h01);
    end
  end

  // Flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdt_to_flag <= 1'b0;
      tmr_ovf_flag <= 1'b0;
      wdt_reset_out <= 1'b0;
    end else begin
      wdt_to_flag <= (wdt_to_flag & ~wdt_to_clr) | wdt_timeout;
      tmr_ovf_flag <= (tmr_ovf_flag & ~tmr_ovf_clr) | timer_wrap;
      wdt_reset_out <= wdt_timeout;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_out <= rd_mux;
    end
  end
endmodule
`default_nettype wire

//--- spwa_props.sv
// Port assertions for the shared prescaler watchdog
`default_nettype none
module spwa_props (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic ext_timer_clk_pin_in,
  input wire logic wdt_enable_in,
  input wire logic wdt_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic asg, fresh, p1, p2;
  wire acc = psel_in & penable_in;
  wire rd = acc & !pwrite_in;
  wire ok_adr = paddr_in[7:4] == 4'h0 && paddr_in[1:0] == 2'h0;
  wire wr_opt = acc & pwrite_in & paddr_in == spwa_pkg::ADDR_OPTION;
  wire wr_clr = acc & pwrite_in & paddr_in == spwa_pkg::ADDR_WDCLEAR;
  // Move back to the watchdog at 1:1 with pin level equal to edge bit
  wire swap = wr_opt & !asg & pwdata_in[5] & pwdata_in[3]
    & pwdata_in[2:0] == 3'h0 & pwdata_in[4] == p2 & wdt_enable_in;
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) {asg, fresh, p2, p1} <= 4'hc;
    else begin
      {p2, p1} <= {p1, ext_timer_clk_pin_in};
      if (wr_opt) {asg, fresh} <= {pwdata_in[3], 1'b0};
    end
  sequence swap_s;
    swap;
  endsequence
  sequence fire_s;
    ##[1:3] wdt_reset_out;
  endsequence
  ready_high_a: assert property (pready_out)
    else $error("pready low");
  err_map_a: assert property (pslverr_out == (acc & !ok_adr))
    else $error("pslverr wrong");
  zero_read_a: assert property (rd & (!ok_adr
    | paddr_in == spwa_pkg::ADDR_WDCLEAR) |-> prdata_out == 32'h0)
    else $error("read not zero");
  opt_reset_a: assert property (rd & fresh
    & paddr_in == spwa_pkg::ADDR_OPTION |-> prdata_out == 32'h0000_00ff)
    else $error("option reset value");
  asg_stat_a: assert property (rd & paddr_in == spwa_pkg::ADDR_STATUS
    |-> prdata_out[spwa_pkg::ST_ASSIGN_BIT] == asg)
    else $error("assign bit");
  wdog_off_a: assert property (!wdt_enable_in [*4] |-> !wdt_reset_out)
    else $error("time-out while off");
  glitch_fire_a: assert property (swap_s |-> fire_s)
    else $error("no reassign time-out");
  clear_quiet_a: assert property (wr_clr |-> ##2 !wdt_reset_out)
    else $error("time-out after clear");
endmodule
bind spwa_watchdog_top spwa_props spwa_props_i (.clk_in, .rstn_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .ext_timer_clk_pin_in, .wdt_enable_in, .wdt_reset_out);
`default_nettype wire

//--- testbench.sv
// Bench for the shared prescaler watchdog
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, pin = 1'b0, en = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, hits;
  logic pready_out, pslverr_out, wdt_reset_out, err;
  int bad_count = 0, comparisons = 0, cycles = 0;
  spwa_watchdog_top #(.WDT_BASE_CYCLES(64)) spwa_watchdog_top_i (.clk_in,
    .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .ext_timer_clk_pin_in(pin),
    .wdt_enable_in(en), .wdt_reset_out);
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic watch(input int n);
    hits = 0;
    repeat (n) begin
      @(posedge clk_in);
      if (wdt_reset_out === 1'b1) hits++;
    end
  endtask
  task automatic set_pin(input logic v);
    pin <= v;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic t_reset();
    apb(1'b0, spwa_pkg::ADDR_OPTION, 32'h0);
    chk(rd, 32'h0000_00ff);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_edge();
    for (int e = 0; e < 2; e++) begin
      set_pin(1'b0);
      apb(1'b1, spwa_pkg::ADDR_OPTION, 32'h20 | (e << 4));
      apb(1'b1, spwa_pkg::ADDR_TIMER, 32'h0);
      set_pin(1'b1);
      set_pin(1'b0);
      set_pin(1'b1);
      apb(1'b0, spwa_pkg::ADDR_TIMER, 32'h0);
      chk(rd, (e == 0) ? 32'h1 : 32'h0);
    end
  endtask
  task automatic t_glitch();
    en <= 1'b1;
    repeat (4) @(posedge clk_in);
    apb(1'b1, spwa_pkg::ADDR_WDCLEAR, 32'h0);
    apb(1'b1, spwa_pkg::ADDR_OPTION, 32'h38);
    watch(4);
    chk(hits, 32'h1);
    apb(1'b0, spwa_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_000d);
  endtask
  task automatic t_quiet();
    logic [31:0] opts [3] = '{32'h28, 32'h18, 32'h39};
    foreach (opts[i]) begin
      apb(1'b1, spwa_pkg::ADDR_OPTION, 32'h20);
      apb(1'b1, spwa_pkg::ADDR_WDCLEAR, 32'h0);
      apb(1'b1, spwa_pkg::ADDR_OPTION, opts[i]);
      watch(8);
      chk(hits, 32'h0);
    end
    apb(1'b1, spwa_pkg::ADDR_WDCLEAR, 32'h0);
    apb(1'b1, spwa_pkg::ADDR_OPTION, 32'h18);
    watch(40);
    chk(hits, 32'h0);
    watch(60);
    chk(hits, 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_edge();
    t_glitch();
    t_quiet();
    give_verdict();
  end
endmodule
`default_nettype wire
